//--- shared/pwc_regs.svh
`ifndef PWC_REGS_SVH
`define PWC_REGS_SVH

// Register byte offsets.
`define PWC_ADDR_MODE 4'h0
`define PWC_ADDR_CTRL 4'h1
`define PWC_ADDR_STAT 4'h2
`define PWC_ADDR_AL   4'h3
`define PWC_ADDR_AH   4'h4
`define PWC_ADDR_BL   4'h5
`define PWC_ADDR_BH   4'h6

// Operating mode codes.
`define PWC_OP_PWM 3'h6
`define PWC_OP_PPG 3'h3

// Counter limits and reset values.
`define PWC_CNT_ZERO 16'h0000
`define PWC_CNT_ONE  16'h0001
`define PWC_CNT_MAX  16'hFFFF
`define PWC_RD_ZERO  8'h00
`define PWC_STATE_RST '0

// Prescaler masks for source clock divide by 1, 4, 16 and 64.
`define PWC_DIV_MASK0 6'h00
`define PWC_DIV_MASK1 6'h03
`define PWC_DIV_MASK2 6'h0F
`define PWC_DIV_MASK3 6'h3F
`define PWC_PRESC_ONE 6'h01

`endif

//--- shared/pwc_pkg.sv
package pwc_pkg;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} pwc_bus_req_t;

	typedef struct packed {
		logic       captureStyleSelect;
		logic       triggerEdgeSelect;
		logic [1:0] sourceClockSelect;
		logic [2:0] opModeSelect;
	} pwc_mode_t;

	typedef struct packed {
		logic doubleBufferEnable;
		logic oneshotSelect;
		logic outputInitialLevel;
		logic overflowIrqEnable;
		logic runControl;
	} pwc_ctrl_t;

	typedef struct packed {
		logic overflowFlag;
		logic captureBFlag;
		logic captureAFlag;
	} pwc_stat_t;

	typedef enum logic [2:0] {
		PH_IDLE,
		PH_ARM,
		PH_HIGH,
		PH_LOW,
		PH_PPG
	} pwc_phase_t;

	typedef struct packed {
		logic [1:0]  inSync;
		logic        inPrev;
		pwc_mode_t   mode;
		pwc_ctrl_t   ctrl;
		pwc_stat_t   stat;
		logic [15:0] cnt;
		logic [15:0] aAct;
		logic [15:0] aBuf;
		logic [15:0] bAct;
		logic [15:0] bBuf;
		logic [7:0]  tmp;
		logic [5:0]  presc;
		pwc_phase_t  phase;
		logic        ppgOut;
		logic        irq;
		logic [7:0]  rdata;
	} pwc_state_t;

endpackage

//--- src/pwc_top.sv
`timescale 1ns/1ps
`include "pwc_regs.svh"
module pwc_top (
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	input  wire logic                  clkEn,
	input  wire pwc_pkg::pwc_bus_req_t busReq,
	output wire logic [7:0]            regRdata,
	input  wire logic                  timerInputPin,
	output wire logic                  pulseOutputPin,
	output wire logic                  timerIrq
);
	import pwc_pkg::*;

	////////////////////////////////////////////////////////////////////////////

	pwc_state_t s_q;
	pwc_state_t s_d;
	pwc_ctrl_t  wrCtrl;
	pwc_stat_t  setStat;
	logic       rise;
	logic       fall;
	logic       startEdge;
	logic       oppEdge;
	logic       tick;
	logic       wrCtl;
	logic       startNow;
	logic       stopNow;
	logic       rdStat;
	logic       counting;
	logic       ovfHit;
	logic [15:0] wrWord;

	function automatic logic [5:0] divMask(input logic [1:0] sel);
		logic [5:0] m;
		m = `PWC_DIV_MASK0;
		unique case (sel)
			2'h0: m = `PWC_DIV_MASK0;
			2'h1: m = `PWC_DIV_MASK1;
			2'h2: m = `PWC_DIV_MASK2;
			2'h3: m = `PWC_DIV_MASK3;
		endcase
		return m;
	endfunction

	////////////////////////////////////////////////////////////////////////////

	// Only the second synchroniser stage and its delayed copy feed edge logic.
	assign rise      = s_q.inSync[1] & ~s_q.inPrev;
	assign fall      = ~s_q.inSync[1] & s_q.inPrev;
	assign startEdge = s_q.mode.triggerEdgeSelect ? fall : rise;
	assign oppEdge   = s_q.mode.triggerEdgeSelect ? rise : fall;
	assign tick      = (s_q.presc & divMask(s_q.mode.sourceClockSelect)) == `PWC_DIV_MASK0;
	assign wrCtrl    = pwc_ctrl_t'(busReq.wdata[4:0]);
	assign wrCtl     = busReq.wr && busReq.addr == `PWC_ADDR_CTRL;
	assign startNow  = wrCtl && wrCtrl.runControl && !s_q.ctrl.runControl;
	assign stopNow   = wrCtl && !wrCtrl.runControl && s_q.ctrl.runControl;
	assign rdStat    = busReq.rd && busReq.addr == `PWC_ADDR_STAT;
	assign wrWord    = {busReq.wdata, s_q.tmp};
	assign counting  = s_q.phase == PH_HIGH || s_q.phase == PH_LOW;
	assign ovfHit    = counting && tick && s_q.cnt == `PWC_CNT_MAX;

	////////////////////////////////////////////////////////////////////////////

	always_comb begin
		s_d = s_q;
		setStat = '0;
		s_d.irq = 1'b0;
		s_d.inSync = {s_q.inSync[0], timerInputPin};
		s_d.inPrev = s_q.inSync[1];
		s_d.presc = s_q.presc + `PWC_PRESC_ONE;

		// Register writes.
		if (busReq.wr) begin
			unique case (busReq.addr)
				`PWC_ADDR_MODE: begin
					if (!s_q.ctrl.runControl) begin
						s_d.mode = pwc_mode_t'(busReq.wdata[6:0]);
					end
				end
				`PWC_ADDR_CTRL: begin
					s_d.ctrl.runControl = wrCtrl.runControl;
					s_d.ctrl.oneshotSelect = wrCtrl.oneshotSelect;
					s_d.ctrl.doubleBufferEnable = wrCtrl.doubleBufferEnable;
					if (!s_q.ctrl.runControl) begin
						s_d.ctrl.overflowIrqEnable = wrCtrl.overflowIrqEnable;
						s_d.ctrl.outputInitialLevel = wrCtrl.outputInitialLevel;
					end
				end
				`PWC_ADDR_AL, `PWC_ADDR_BL: begin
					s_d.tmp = busReq.wdata;
				end
				`PWC_ADDR_AH: begin
					s_d.aBuf = wrWord;
					if (!(s_q.ctrl.runControl && s_q.ctrl.doubleBufferEnable)) begin
						s_d.aAct = wrWord;
					end
				end
				`PWC_ADDR_BH: begin
					s_d.bBuf = wrWord;
					if (!(s_q.ctrl.runControl && s_q.ctrl.doubleBufferEnable)) begin
						s_d.bAct = wrWord;
					end
				end
				default: begin
				end
			endcase
		end

		// Timer behaviour.
		if (startNow) begin
			s_d.cnt = `PWC_CNT_ZERO;
			s_d.phase = PH_IDLE;
			if (s_q.mode.opModeSelect == `PWC_OP_PWM) begin
				s_d.phase = PH_ARM;
				s_d.aAct = `PWC_CNT_ZERO;
				s_d.aBuf = `PWC_CNT_ZERO;
				s_d.bAct = `PWC_CNT_ZERO;
				s_d.bBuf = `PWC_CNT_ZERO;
			end else if (s_q.mode.opModeSelect == `PWC_OP_PPG) begin
				s_d.phase = PH_PPG;
				// A level written together with the start bit applies at once.
				s_d.ppgOut = s_d.ctrl.outputInitialLevel;
			end
		end else if (s_q.ctrl.runControl && !stopNow) begin
			unique case (s_q.phase)
				PH_IDLE: begin
					s_d.phase = PH_IDLE;
				end
				PH_ARM: begin
					// A leading opposite edge falls through here untouched.
					if (startEdge) begin
						s_d.irq = 1'b1;
						s_d.phase = PH_HIGH;
					end
				end
				PH_HIGH: begin
					if (oppEdge) begin
						s_d.bAct = s_q.cnt;
						s_d.bBuf = s_q.cnt;
						setStat.captureBFlag = 1'b1;
						s_d.irq = 1'b1;
						if (s_q.mode.captureStyleSelect) begin
							s_d.phase = PH_ARM;
							s_d.cnt = `PWC_CNT_ZERO;
						end else begin
							// Counting runs on through the capture so that A spans the period.
							s_d.phase = PH_LOW;
							if (tick) begin
								s_d.cnt = s_q.cnt + `PWC_CNT_ONE;
							end
						end
					end else if (tick) begin
						s_d.cnt = s_q.cnt + `PWC_CNT_ONE;
					end
				end
				PH_LOW: begin
					if (startEdge) begin
						s_d.aAct = s_q.cnt;
						s_d.aBuf = s_q.cnt;
						setStat.captureAFlag = 1'b1;
						s_d.irq = 1'b1;
						s_d.cnt = `PWC_CNT_ZERO;
						s_d.phase = PH_HIGH;
					end else if (tick) begin
						s_d.cnt = s_q.cnt + `PWC_CNT_ONE;
					end
				end
				PH_PPG: begin
					if (tick) begin
						if (s_q.cnt == s_q.aAct) begin
							s_d.ppgOut = s_q.ctrl.outputInitialLevel;
							s_d.irq = 1'b1;
							s_d.cnt = `PWC_CNT_ZERO;
							s_d.aAct = s_d.aBuf;
							s_d.bAct = s_d.bBuf;
							if (s_q.ctrl.oneshotSelect) begin
								s_d.ctrl.runControl = 1'b0;
							end
						end else begin
							if (s_q.cnt == s_q.bAct) begin
								s_d.ppgOut = ~s_q.ctrl.outputInitialLevel;
							end
							// Without the double buffer a short value waits for the wrap.
							s_d.cnt = s_q.cnt + `PWC_CNT_ONE;
						end
					end
				end
				default: begin
					s_d.phase = PH_IDLE;
				end
			endcase
			if (ovfHit) begin
				setStat.overflowFlag = 1'b1;
				if (s_q.ctrl.overflowIrqEnable) begin
					s_d.irq = 1'b1;
				end
			end
		end

		// A stopped timer holds zero and shows the idle level.
		if (!s_d.ctrl.runControl) begin
			s_d.phase = PH_IDLE;
			s_d.cnt = `PWC_CNT_ZERO;
			s_d.ppgOut = s_d.ctrl.outputInitialLevel;
		end

		// A flag raised in the clearing cycle survives the read.
		s_d.stat = (rdStat ? pwc_stat_t'('0) : s_q.stat) | setStat;

		// Read port.
		s_d.rdata = `PWC_RD_ZERO;
		if (busReq.rd) begin
			unique case (busReq.addr)
				`PWC_ADDR_MODE: s_d.rdata = {1'b0, s_q.mode};
				`PWC_ADDR_CTRL: s_d.rdata = {3'h0, s_q.ctrl};
				`PWC_ADDR_STAT: s_d.rdata = {5'h00, s_q.stat};
				`PWC_ADDR_AL:   s_d.rdata = s_q.aBuf[7:0];
				`PWC_ADDR_AH:   s_d.rdata = s_q.aBuf[15:8];
				`PWC_ADDR_BL:   s_d.rdata = s_q.bBuf[7:0];
				`PWC_ADDR_BH:   s_d.rdata = s_q.bBuf[15:8];
				default:        s_d.rdata = `PWC_RD_ZERO;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= `PWC_STATE_RST;
		end else if (clkEn) begin
			s_q <= s_d;
		end
	end

	assign regRdata       = s_q.rdata;
	assign pulseOutputPin = s_q.ppgOut;
	assign timerIrq       = s_q.irq;

	////////////////////////////////////////////////////////////////////////////

	// Step antecedents require clkEn so that a frozen cycle never counts as a step; the lock and stop checks do not.
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	AST_START_ZERO: assert property (
		clkEn && startNow && s_q.mode.opModeSelect == `PWC_OP_PWM
		|=> s_q.aBuf == `PWC_CNT_ZERO && s_q.bBuf == `PWC_CNT_ZERO && s_q.phase == PH_ARM)
		else $error("Start did not clear capture registers.");

	AST_MODE_LOCK: assert property (
		s_q.ctrl.runControl |=> $stable(s_q.mode) && $stable(s_q.ctrl.overflowIrqEnable))
		else $error("Mode changed while running.");

	AST_CAP_B: assert property (
		clkEn && !stopNow && s_q.phase == PH_HIGH && oppEdge
		|=> timerIrq && s_q.stat.captureBFlag && s_q.bBuf == $past(s_q.cnt))
		else $error("Opposite edge did not capture B.");

	AST_CAP_A: assert property (
		clkEn && !stopNow && s_q.phase == PH_LOW && startEdge
		|=> timerIrq && s_q.stat.captureAFlag && s_q.aBuf == $past(s_q.cnt)
		&& s_q.cnt == `PWC_CNT_ZERO)
		else $error("Start edge did not capture A.");

	AST_SINGLE: assert property (
		clkEn && !stopNow && s_q.phase == PH_HIGH && oppEdge && s_q.mode.captureStyleSelect
		|=> s_q.phase == PH_ARM && s_q.cnt == `PWC_CNT_ZERO ##1 s_q.cnt == `PWC_CNT_ZERO)
		else $error("Single-edge capture did not stop the counter.");

	AST_OVF: assert property (
		clkEn && !stopNow && ovfHit
		|=> s_q.stat.overflowFlag && (!$past(s_q.ctrl.overflowIrqEnable) || timerIrq))
		else $error("Overflow not flagged.");

	AST_RD_CLR: assert property (
		clkEn && rdStat && setStat == '0 |=> s_q.stat == '0)
		else $error("Status read did not clear flags.");

	AST_STOP: assert property (
		$fell(s_q.ctrl.runControl)
		|-> s_q.cnt == `PWC_CNT_ZERO && pulseOutputPin == s_q.ctrl.outputInitialLevel)
		else $error("Stop left counter or output unrestored.");

	AST_ARM_IGN: assert property (
		clkEn && s_q.phase == PH_ARM && oppEdge && !s_q.inSync[1] == !s_q.mode.triggerEdgeSelect
		&& !ovfHit |=> !timerIrq && $stable(s_q.stat.captureBFlag) || $past(rdStat))
		else $error("Leading opposite edge was acted upon.");

	AST_PPG_A: assert property (
		clkEn && !stopNow && s_q.phase == PH_PPG && tick && s_q.cnt == s_q.aAct
		|=> timerIrq && pulseOutputPin == s_q.ctrl.outputInitialLevel
		&& s_q.cnt == `PWC_CNT_ZERO)
		else $error("Period match mishandled.");

	AST_EDGE_POL: assert property (
		clkEn && s_q.phase == PH_ARM && s_q.inSync[1] == s_q.mode.triggerEdgeSelect
		|=> s_q.phase != PH_HIGH)
		else $error("Start edge polarity ignored.");

	AST_START_EDGE: assert property (
		clkEn && !stopNow && s_q.phase == PH_ARM && startEdge
		|=> timerIrq && s_q.phase == PH_HIGH && s_q.cnt == `PWC_CNT_ZERO)
		else $error("Start edge did not begin the measurement.");

	AST_COUNT_HIGH: assert property (
		clkEn && !stopNow && s_q.phase == PH_HIGH && !oppEdge && tick
		|=> s_q.cnt == $past(s_q.cnt) + `PWC_CNT_ONE)
		else $error("Counter did not advance on a tick.");

	AST_DOUBLE_RUN: assert property (
		clkEn && !stopNow && s_q.phase == PH_HIGH && oppEdge
		&& !s_q.mode.captureStyleSelect && tick
		|=> s_q.phase == PH_LOW && s_q.cnt == $past(s_q.cnt) + `PWC_CNT_ONE)
		else $error("Double-edge capture halted the counter.");

	AST_PPG_START: assert property (
		clkEn && startNow && s_q.mode.opModeSelect == `PWC_OP_PPG
		|=> s_q.phase == PH_PPG && pulseOutputPin == s_q.ctrl.outputInitialLevel)
		else $error("Pulse generator did not start at its idle level.");

	AST_LEVEL_LOCK: assert property (
		s_q.ctrl.runControl |=> $stable(s_q.ctrl.outputInitialLevel))
		else $error("Initial level changed while running.");

	AST_PPG_B: assert property (
		clkEn && !stopNow && s_q.phase == PH_PPG && tick && s_q.cnt == s_q.bAct
		&& s_q.cnt != s_q.aAct |=> pulseOutputPin == !s_q.ctrl.outputInitialLevel)
		else $error("Reversal match did not invert the output.");

	AST_ONESHOT: assert property (
		clkEn && !stopNow && s_q.phase == PH_PPG && tick && s_q.cnt == s_q.aAct
		&& s_q.ctrl.oneshotSelect |=> !s_q.ctrl.runControl && s_q.phase == PH_IDLE)
		else $error("One-shot pulse did not stop the timer.");

	AST_CONT: assert property (
		clkEn && !stopNow && s_q.phase == PH_PPG && tick && s_q.cnt == s_q.aAct
		&& !s_q.ctrl.oneshotSelect |=> s_q.ctrl.runControl && s_q.phase == PH_PPG)
		else $error("Continuous output stopped at the period match.");

	AST_DBUF_LOAD: assert property (
		clkEn && !stopNow && s_q.phase == PH_PPG && tick && s_q.cnt == s_q.aAct
		|=> s_q.aAct == s_q.aBuf && s_q.bAct == s_q.bBuf)
		else $error("Buffered values not loaded at the period match.");

	AST_DBUF_HOLD: assert property (
		clkEn && s_q.phase == PH_PPG && s_q.ctrl.doubleBufferEnable
		&& !(tick && s_q.cnt == s_q.aAct) |=> $stable(s_q.aAct) && $stable(s_q.bAct))
		else $error("Active compare value changed between period matches.");

	AST_COMMIT: assert property (
		clkEn && busReq.wr && busReq.addr == `PWC_ADDR_AH && !s_q.ctrl.runControl
		|=> s_q.aAct == {$past(busReq.wdata), $past(s_q.tmp)} && s_q.aBuf == s_q.aAct)
		else $error("High-byte write did not commit the held low byte.");

endmodule

//--- bench/pwc_partner.sv
`timescale 1ns/1ps
module pwc_partner (
	input  wire logic        sys_clk,
	input  wire logic        idleLvl,
	input  wire logic        pulseOutputPin,
	output logic             timerInputPin,
	output logic [15:0]      activeLen
);
	logic [15:0] runLen = 16'h0000;
	initial timerInputPin = 1'b0;
	initial activeLen = 16'h0000;
	// Each level is held whole clock cycles; shorter levels are lost in the synchroniser.
	task automatic drive(input logic lvl, input int n);
		timerInputPin <= lvl;
		repeat (n) @(posedge sys_clk);
	endtask
	// Width of the last excursion of the generated pulse away from its idle level.
	always @(posedge sys_clk) begin
		if (pulseOutputPin !== idleLvl) begin
			runLen <= runLen + 16'h0001;
		end else if (runLen != 16'h0000) begin
			activeLen <= runLen;
			runLen    <= 16'h0000;
		end
	end
endmodule

//--- bench/test_pulse_width_capture_and_ppg.sv
`timescale 1ns/1ps
`include "pwc_regs.svh"
module test_pulse_width_capture_and_ppg;
	import pwc_pkg::*;
	logic         sys_clk;
	logic         rst_n;
	logic         clkEn;
	pwc_bus_req_t busReq;
	logic [7:0]   regRdata;
	logic         timerInputPin;
	logic         pulseOutputPin;
	logic         timerIrq;
	logic         idleLvl;
	logic [15:0]  activeLen;
	logic [15:0]  v;
	logic [8:0]   expQ[$];
	logic         rdLast;
	int           error_cnt;
	int           compares;
	int           irqCnt;
	int           gapCnt;
	int           lastGap;
	int           base;
	pwc_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .busReq(busReq),
		.regRdata(regRdata), .timerInputPin(timerInputPin),
		.pulseOutputPin(pulseOutputPin), .timerIrq(timerIrq));
	pwc_partner i_part (.sys_clk(sys_clk), .idleLvl(idleLvl), .pulseOutputPin(pulseOutputPin),
		.timerInputPin(timerInputPin), .activeLen(activeLen));
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("Comparisons %0d, errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Read data arrive one cycle after the strobe, so the note is taken off the queue then.
	always @(posedge sys_clk) begin
		if (timerIrq === 1'b1) begin
			irqCnt++;
			lastGap = gapCnt;
			gapCnt  = 0;
		end
		gapCnt++;
		if (rdLast === 1'b1 && expQ.size() > 0) begin
			if (expQ[0][8]) check(16'(regRdata), 16'(expQ[0][7:0]));
			void'(expQ.pop_front());
		end
		rdLast = busReq.rd;
	end
	task automatic bus(input logic [3:0] a, input logic [7:0] d, input logic r,
		input logic [8:0] e);
		if (r) expQ.push_back(e);
		busReq <= '{addr: a, wdata: d, wr: !r, rd: r};
		@(posedge sys_clk);
		busReq <= '0;
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus(a, d, 1'b0, 9'h000);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		bus(a, 8'h00, 1'b1, {1'b1, e});
	endtask
	task automatic wr16(input logic [3:0] a, input logic [15:0] val);
		wr(a, val[7:0]);
		wr(a + 4'h1, val[15:8]);
	endtask
	task automatic rd16(input logic [3:0] a, output logic [15:0] val);
		bus(a, 8'h00, 1'b1, 9'h000);
		val[7:0] = regRdata;
		bus(a + 4'h1, 8'h00, 1'b1, 9'h000);
		val[15:8] = regRdata;
	endtask
	task automatic waitIrq(input int target);
		for (int k = 0; k < 3000 && irqCnt < target; k++) @(posedge sys_clk);
		if (irqCnt < target) begin
			error_cnt++;
			$display("MISMATCH at %0t: interrupt wait ran out", $time);
			close_out();
		end
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic measure(input logic [7:0] mode, input logic [7:0] expStat);
		logic [15:0] hLen;
		logic [15:0] lLen;
		logic [15:0] capB;
		hLen = 16'($urandom_range(40, 8));
		lLen = 16'($urandom_range(40, 8));
		wr(`PWC_ADDR_CTRL, 8'h00);
		wr(`PWC_ADDR_MODE, mode);
		i_part.drive(!mode[5], 4);
		wr(`PWC_ADDR_CTRL, 8'h01);
		rd16(`PWC_ADDR_AL, v);
		check(v, 16'h0000);
		wr(`PWC_ADDR_MODE, 8'h03);
		rd(`PWC_ADDR_MODE, mode);
		base = irqCnt;
		i_part.drive(mode[5], lLen);
		i_part.drive(!mode[5], hLen);
		i_part.drive(mode[5], lLen);
		i_part.drive(!mode[5], hLen);
		i_part.drive(mode[5], 8);
		check(16'(irqCnt - base), 16'h0004);
		rd(`PWC_ADDR_STAT, expStat);
		rd(`PWC_ADDR_STAT, 8'h00);
		rd16(`PWC_ADDR_BL, capB);
		if (capB + 16'h0002 < hLen || capB > hLen + 16'h0001) check(capB, hLen);
		rd16(`PWC_ADDR_AL, v);
		if (!mode[6]) check(v - capB, lLen);
		else check(v, 16'h0000);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n     = 1'b0;
		clkEn     = 1'b1;
		busReq    = '0;
		idleLvl   = 1'b0;
		rdLast    = 1'b0;
		error_cnt = 0;
		compares  = 0;
		irqCnt    = 0;
		gapCnt    = 0;
		lastGap   = 0;
		void'($urandom(65));
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		for (int i = 0; i < 4; i++) begin
			measure({1'b0, i[1], i[0], 2'b00, `PWC_OP_PWM}, i[1] ? 8'h02 : 8'h03);
		end
		// Overflow takes a full 16-bit count; it dominates the run time.
		wr(`PWC_ADDR_CTRL, 8'h00);
		wr(`PWC_ADDR_MODE, 8'h06);
		i_part.drive(1'b0, 4);
		wr(`PWC_ADDR_CTRL, 8'h03);
		base = irqCnt;
		i_part.drive(1'b1, 65600);
		check(16'(irqCnt - base), 16'h0002);
		rd(`PWC_ADDR_STAT, 8'h04);
		wr(`PWC_ADDR_CTRL, 8'h00);
		wr(`PWC_ADDR_MODE, {5'h00, `PWC_OP_PPG});
		wr16(`PWC_ADDR_AL, 16'h0014);
		wr16(`PWC_ADDR_BL, 16'h0008);
		idleLvl <= 1'b1;
		wr(`PWC_ADDR_CTRL, 8'h04);
		@(posedge sys_clk);
		check(16'(pulseOutputPin), 16'h0001);
		wr(`PWC_ADDR_CTRL, 8'h05);
		waitIrq(irqCnt + 2);
		check(16'(lastGap), 16'h0015);
		check(activeLen, 16'h000C);
		wr(`PWC_ADDR_CTRL, 8'h09);
		waitIrq(irqCnt + 1);
		repeat (4) @(posedge sys_clk);
		rd(`PWC_ADDR_CTRL, 8'h0C);
		check(16'(pulseOutputPin), 16'h0001);
		idleLvl <= 1'b0;
		wr(`PWC_ADDR_CTRL, 8'h11);
		check(16'(pulseOutputPin), 16'h0000);
		base = irqCnt;
		waitIrq(base + 1);
		wr16(`PWC_ADDR_AL, 16'h001E);
		waitIrq(base + 2);
		check(16'(lastGap), 16'h0015);
		waitIrq(base + 3);
		check(16'(lastGap), 16'h001F);
		wr(`PWC_ADDR_CTRL, 8'h00);
		wr(`PWC_ADDR_CTRL, 8'h09);
		waitIrq(irqCnt + 1);
		repeat (4) @(posedge sys_clk);
		rd(`PWC_ADDR_CTRL, 8'h08);
		check(activeLen, 16'h0016);
		close_out();
	end
endmodule
